// file: pkg/bridge_pwm_pkg.sv
// Constants for the half-bridge PWM and mode control block.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package bridge_pwm_pkg;
    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int NUM_BRIDGES = 6;
    localparam int NUM_CHANNELS = 3;
    localparam int NUM_TIMEBASES = 3;
    localparam int DUTY_W = 8;
    localparam int FREQ_W = 2;
    localparam int MODE_W = 2;
    localparam int STEP_W = 14;
    // ****************************************************************
    // Frequency codes and reset values
    // ****************************************************************
    localparam logic [1:0] FREQ_STOP = 2'h0;
    localparam logic [1:0] FREQ_80 = 2'h1;
    localparam logic [1:0] FREQ_100 = 2'h2;
    localparam logic [1:0] FREQ_200 = 2'h3;
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [5:0] FREQ_RST = 6'h00;
    localparam logic [23:0] DUTY_RST = 24'h000000;
    localparam logic [11:0] MODE_RST = 12'h000;
    localparam logic [5:0] ACT_RST = 6'h00;
    localparam logic [5:0] FW_RST = 6'h00;
    localparam logic [7:0] PHASE_LAST = 8'hFF;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_MHZ = 200;
    localparam int F80_HZ = 80;
    localparam int F100_HZ = 100;
    localparam int F200_HZ = 200;
    localparam int DUTY_STEPS = 256;
    // Clocks per duty step, rounded down so the period never runs long
    localparam int STEP80_CYC = CLK_HZ / (F80_HZ * DUTY_STEPS);
    localparam int STEP100_CYC = CLK_HZ / (F100_HZ * DUTY_STEPS);
    localparam int STEP200_CYC = CLK_HZ / (F200_HZ * DUTY_STEPS);
    // Cross-conduction dead times of the gate stage
    localparam int DEAD_HL_NS = 1000;
    localparam int DEAD_LH_NS = 1000;
    localparam int DEAD_CYC = ((DEAD_HL_NS + DEAD_LH_NS) * CLK_MHZ + 999) / 1000;
endpackage

// file: hdl/bridge_pwm_ctrl.sv
// Mode control, configuration store and PWM generation for six half-bridges.
// Assumes the serial interface decoder writes on i_mclk and gate drive follows outputs.
// Operation
// - Logic supply power-on clears every setting and turns all switches off.
// - Power-stage supply dropout keeps settings; outputs resume when it returns.
// - Enable high gives normal mode, charge pump on, configuration accepted.
// - Enable low gives sleep: switches off, all settings back to reset.
// - Logic supply low clears logic and turns outputs off until it returns.
// - After any reset the reset report flag reads cleared in normal mode.
// - Each bridge maps to one of three channels, each with 8-bit duty.
// - Each channel runs at 80 Hz, 100 Hz or 200 Hz.
// - Frequency code 01 is 80 Hz, 10 is 100 Hz, 11 is 200 Hz.
// - Frequency code 00 stops the channel with its PWM output off.
// - Frequency and duty changes apply at period end, or at once on a stopped channel, never glitching output.
// - Active or passive free-wheeling is selectable; reset selects passive.
// - Active free-wheeling on a running channel acts only when both on-times exceed summed dead times.
// - Each output is driven statically by activation bits or by PWM.
// - Mode 00 uses no channel; with activation bits clear output is tri-state.
// - Stopped channel with active free-wheel holds high side off, low side on, if the bridge's high side is activated.
`timescale 1ns/10ps
module bridge_pwm_ctrl #(
    parameter int STEP80 = bridge_pwm_pkg::STEP80_CYC,
    parameter int STEP100 = bridge_pwm_pkg::STEP100_CYC
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Pins and supply monitors
    input wire logic i_en,
    input wire logic i_vdd_ok,
    input wire logic i_vs_ok,
    // Register writes from the serial interface
    input wire logic i_wr_freq,
    input wire logic [5:0] i_freq,
    input wire logic i_wr_duty,
    input wire logic [23:0] i_duty,
    input wire logic i_wr_assign,
    input wire logic [11:0] i_assign,
    input wire logic i_wr_act,
    input wire logic [5:0] i_upper_act,
    input wire logic [5:0] i_lower_act,
    input wire logic i_wr_fw,
    input wire logic [5:0] i_freewheel,
    input wire logic i_wr_flag_set,
    // Gate drive and status
    output logic [5:0] o_high_side_switch,
    output logic [5:0] o_low_side_switch,
    output logic o_charge_pump_on,
    output logic o_normal_mode,
    output logic o_reset_report_flag,
    output logic [5:0] o_channel_frequency_register,
    output logic [23:0] o_duty_cycle_register,
    output logic [11:0] o_bridge_channel_assign_register,
    output logic [5:0] o_bridge_activation_upper,
    output logic [5:0] o_bridge_activation_lower,
    output logic [5:0] o_freewheel_select_register
);
    import bridge_pwm_pkg::*;

    // ****************************************************************
    // Pin synchronisers and mode
    // ****************************************************************
    logic en_m_q, en_s_q, vdd_m_q, vdd_s_q, vs_m_q, vs_s_q;
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            en_m_q <= 1'b0;
            en_s_q <= 1'b0;
            vdd_m_q <= 1'b0;
            vdd_s_q <= 1'b0;
            vs_m_q <= 1'b0;
            vs_s_q <= 1'b0;
        end else begin
            en_m_q <= i_en;
            en_s_q <= en_m_q;
            vdd_m_q <= i_vdd_ok;
            vdd_s_q <= vdd_m_q;
            vs_m_q <= i_vs_ok;
            vs_s_q <= vs_m_q;
        end
    end

    wire logic_rst = i_srst | ~vdd_s_q | ~en_s_q;
    wire drive_ok = ~logic_rst & vs_s_q;

    // ****************************************************************
    // Configuration store
    // ****************************************************************
    logic [5:0] freq_q;
    logic [23:0] duty_q;
    logic [11:0] mode_q;
    logic [5:0] hs_act_q, ls_act_q, fw_q;
    logic flag_q;
    always_ff @(posedge i_mclk) begin
        if (logic_rst) begin
            freq_q <= FREQ_RST;
            duty_q <= DUTY_RST;
            mode_q <= MODE_RST;
            hs_act_q <= ACT_RST;
            ls_act_q <= ACT_RST;
            fw_q <= FW_RST;
            flag_q <= 1'b0;
        end else begin
            if (i_wr_freq) freq_q <= i_freq;
            if (i_wr_duty) duty_q <= i_duty;
            if (i_wr_assign) mode_q <= i_assign;
            if (i_wr_act) begin
                hs_act_q <= i_upper_act;
                ls_act_q <= i_lower_act;
            end
            if (i_wr_fw) fw_q <= i_freewheel;
            if (i_wr_flag_set) flag_q <= 1'b1;
        end
    end

    // ****************************************************************
    // Free-running timebases, one per frequency
    // ****************************************************************
    logic [STEP_W-1:0] step_w [NUM_TIMEBASES];
    logic [7:0] phase_w [NUM_TIMEBASES];
    logic wrap_w [NUM_TIMEBASES];
    assign step_w[0] = STEP_W'(STEP80);
    assign step_w[1] = STEP_W'(STEP100);
    assign step_w[2] = STEP_W'(STEP200_CYC);

    for (genvar t = 0; t < NUM_TIMEBASES; t++) begin : g_tb
        logic [STEP_W-1:0] pre_q;
        logic [7:0] phase_q;
        wire tick = (pre_q == step_w[t] - STEP_W'(1));
        assign phase_w[t] = phase_q;
        assign wrap_w[t] = tick & (phase_q == PHASE_LAST);
        always_ff @(posedge i_mclk) begin
            if (logic_rst) begin
                pre_q <= '0;
                phase_q <= 8'h00;
            end else begin
                pre_q <= tick ? '0 : pre_q + STEP_W'(1);
                if (tick) phase_q <= phase_q + 8'h01;
            end
        end
    end

    // ****************************************************************
    // PWM channels with period-aligned update
    // ****************************************************************
    logic [2:0] pwm_on, ch_run, fw_ok;
    logic [1:0] act_freq_w [NUM_CHANNELS];
    logic [7:0] act_duty_w [NUM_CHANNELS];
    logic upd_w [NUM_CHANNELS];

    for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_ch
        logic [1:0] act_freq_q;
        logic [7:0] act_duty_q;
        wire run = (act_freq_q != FREQ_STOP);
        // Stopped channel parks on timebase 0 so no index runs past the array
        wire [1:0] tb = run ? act_freq_q - 2'h1 : 2'h0;
        wire upd = ~run | wrap_w[tb];
        wire [22:0] on_hi = 23'(act_duty_q) * 23'(step_w[tb]);
        wire [22:0] on_lo = 23'(9'(DUTY_STEPS) - 9'(act_duty_q)) * 23'(step_w[tb]);
        assign act_freq_w[c] = act_freq_q;
        assign act_duty_w[c] = act_duty_q;
        assign upd_w[c] = upd;
        assign ch_run[c] = run;
        assign pwm_on[c] = run & (phase_w[tb] < act_duty_q);
        assign fw_ok[c] = (on_hi > 23'(DEAD_CYC)) & (on_lo > 23'(DEAD_CYC));
        always_ff @(posedge i_mclk) begin
            if (logic_rst) begin
                act_freq_q <= FREQ_STOP;
                act_duty_q <= 8'h00;
            end else if (upd) begin
                act_freq_q <= freq_q[2*c +: 2];
                act_duty_q <= duty_q[8*c +: 8];
            end
        end
    end

    // ****************************************************************
    // Bridge output selection
    // ****************************************************************
    logic [5:0] hs_n, ls_n;
    for (genvar b = 0; b < NUM_BRIDGES; b++) begin : g_br
        wire [1:0] mode = mode_q[2*b +: 2];
        wire stat = (mode == MODE_NONE);
        wire [1:0] ch = stat ? 2'h0 : mode - 2'h1;
        wire p = pwm_on[ch];
        wire r = ch_run[ch];
        wire ok = fw_ok[ch];
        wire fw = fw_q[b];
        wire ha = hs_act_q[b];
        wire la = ls_act_q[b];
        wire hs_pwm = ha ? (r & p) : (la & fw & r & ~p & ok);
        wire ls_pwm = ha ? (fw & (~r | (~p & ok))) : (la & r & p);
        assign hs_n[b] = stat ? (ha & ~la) : hs_pwm;
        assign ls_n[b] = stat ? (la & ~ha) : ls_pwm;
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_high_side_switch <= 6'h00;
            o_low_side_switch <= 6'h00;
            o_charge_pump_on <= 1'b0;
            o_normal_mode <= 1'b0;
        end else begin
            o_high_side_switch <= drive_ok ? hs_n : 6'h00;
            o_low_side_switch <= drive_ok ? ls_n : 6'h00;
            o_charge_pump_on <= ~logic_rst;
            o_normal_mode <= ~logic_rst;
        end
    end

    assign o_reset_report_flag = flag_q;
    assign o_channel_frequency_register = freq_q;
    assign o_duty_cycle_register = duty_q;
    assign o_bridge_channel_assign_register = mode_q;
    assign o_bridge_activation_upper = hs_act_q;
    assign o_bridge_activation_lower = ls_act_q;
    assign o_freewheel_select_register = fw_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    sequence sleep_s;
        !en_s_q;
    endsequence
    sequence cleared_s;
        freq_q == FREQ_RST && duty_q == DUTY_RST && fw_q == FW_RST;
    endsequence

    vdd_clear_a: assert property (!vdd_s_q |=> cleared_s and o_high_side_switch == 6'h00)
        else $error("logic supply low did not clear state");
    vs_keep_a: assert property (!vs_s_q && !logic_rst && !i_wr_freq |=>
        $stable(freq_q) && o_high_side_switch == 6'h00 && o_low_side_switch == 6'h00)
        else $error("power stage dropout lost settings or drove outputs");
    normal_pump_a: assert property (!logic_rst |=> o_charge_pump_on && o_normal_mode)
        else $error("charge pump not running in normal mode");
    sleep_off_a: assert property (sleep_s |=> cleared_s ##1 o_low_side_switch == 6'h00)
        else $error("sleep did not reset settings and outputs");
    vdd_off_a: assert property (!vdd_s_q ##1 !vdd_s_q |-> !o_normal_mode && mode_q == MODE_RST)
        else $error("logic still active with supply low");
    flag_clear_a: assert property (logic_rst |=> !o_reset_report_flag)
        else $error("reset report flag not cleared");
    stop_off_a: assert property (act_freq_w[0] == FREQ_STOP |-> !pwm_on[0])
        else $error("stopped channel produced PWM");
    duty_hold_a: assert property (!logic_rst && !upd_w[0] |=> $stable(act_duty_w[0]))
        else $error("duty changed mid period");
    fw_default_a: assert property (logic_rst ##1 !logic_rst |-> fw_q == FW_RST)
        else $error("free-wheel not passive after reset");
    tristate_a: assert property (drive_ok && mode_q[1:0] == MODE_NONE && !hs_act_q[0]
        && !ls_act_q[0] |=> !o_high_side_switch[0] && !o_low_side_switch[0])
        else $error("unassigned idle bridge not tri-stated");
    stop_fw_a: assert property (drive_ok && mode_q[1:0] == 2'h1 && hs_act_q[0] && fw_q[0]
        && !ch_run[0] |=> !o_high_side_switch[0] && o_low_side_switch[0])
        else $error("stopped active free-wheel bridge wrong");
endmodule

// file: test/host_model.sv
// Host side model: issues whole-register writes to the control block.
// Assumes writes are sampled on the rising edge of i_mclk.
`timescale 1ns/10ps
module host_model (
    // Clock
    input wire logic i_mclk,
    // Write strobes: freq, duty, assign, act, freewheel, flag set
    output logic [5:0] o_wr,
    output logic [23:0] o_data
);
    initial begin
        o_wr = 6'h00;
        o_data = 24'h000000;
    end
    // One strobe per call, data held across the sampling edge
    task automatic put(input int k, input logic [23:0] v);
        @(negedge i_mclk);
        o_wr[k] = 1'b1;
        o_data = v;
        @(negedge i_mclk);
        o_wr = 6'h00;
        // Released bus must not keep showing the last value
        o_data = ~v;
    endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the half-bridge PWM and mode control block.
// Assumes short timebase steps: 80 Hz step 4, 100 Hz step 3.
`timescale 1ns/10ps
module testbench;
    import bridge_pwm_pkg::*;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic i_en = 1'b1;
    logic i_vdd_ok = 1'b1;
    logic i_vs_ok = 1'b1;
    logic [5:0] wr;
    logic [23:0] hd;
    logic [5:0] hs, ls, fq, up, lo, fw;
    logic cp, nm, flag;
    logic [23:0] dc;
    logic [11:0] asg;
    int bad_count = 0;
    int n_checks = 0;
    int c;
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    host_model host_model_inst (.i_mclk(i_mclk), .o_wr(wr), .o_data(hd));
    bridge_pwm_ctrl #(.STEP80(4), .STEP100(3)) bridge_pwm_ctrl_inst (
        .i_mclk(i_mclk), .i_srst(i_srst), .i_en(i_en), .i_vdd_ok(i_vdd_ok),
        .i_vs_ok(i_vs_ok), .i_wr_freq(wr[0]), .i_freq(hd[5:0]), .i_wr_duty(wr[1]),
        .i_duty(hd), .i_wr_assign(wr[2]), .i_assign(hd[11:0]), .i_wr_act(wr[3]),
        .i_upper_act(hd[5:0]), .i_lower_act(hd[11:6]), .i_wr_fw(wr[4]),
        .i_freewheel(hd[5:0]), .i_wr_flag_set(wr[5]), .o_high_side_switch(hs),
        .o_low_side_switch(ls), .o_charge_pump_on(cp), .o_normal_mode(nm),
        .o_reset_report_flag(flag), .o_channel_frequency_register(fq),
        .o_duty_cycle_register(dc), .o_bridge_channel_assign_register(asg),
        .o_bridge_activation_upper(up), .o_bridge_activation_lower(lo),
        .o_freewheel_select_register(fw));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // High-side on-count of bridge 0 over n cycles
    task automatic hi_count(input int n);
        c = 0;
        repeat (n) begin
            @(negedge i_mclk);
            c += int'(hs[0] === 1'b1);
        end
    endtask
    // Low-side on-count of bridge 0 over n cycles
    task automatic lo_count(input int n);
        c = 0;
        repeat (n) begin
            @(negedge i_mclk);
            c += int'(ls[0] === 1'b1);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        chk({fq, dc, asg}, 64'h0);
        chk({up, lo, fw}, 64'h0);
        chk({hs, ls}, 64'h0);
        chk({cp, nm, flag}, 64'h6);
        $display("reset test done");
    endtask
    task automatic t_static();
        host_model_inst.put(3, {12'h0, 6'h06, 6'h05});
        chk({up, lo}, 64'h146);
        wait_n(2);
        chk(hs, 64'h01);
        chk(ls, 64'h02);
        host_model_inst.put(3, 24'h0);
        wait_n(2);
        chk({hs, ls}, 64'h0);
        $display("static test done");
    endtask
    task automatic t_pwm();
        host_model_inst.put(0, 24'h0);
        host_model_inst.put(4, 24'h0);
        host_model_inst.put(2, 24'h001);
        host_model_inst.put(1, 24'h000040);
        host_model_inst.put(0, 24'h01);
        host_model_inst.put(3, 24'h01);
        chk(fq, 64'(FREQ_80));
        chk({asg, dc}, 64'h001000040);
        wait_n(2048);
        hi_count(1024);
        chk(c, 64'd256);
        host_model_inst.put(1, 24'h000080);
        host_model_inst.put(0, 24'h02);
        wait_n(3072);
        hi_count(768);
        chk(c, 64'd384);
        chk(ls, 64'h0);
        $display("pwm test done");
    endtask
    task automatic t_stop();
        host_model_inst.put(4, 24'h01);
        chk(fw, 64'h01);
        lo_count(768);
        chk(c, 64'd0);
        host_model_inst.put(0, 24'h00);
        wait_n(800);
        hi_count(768);
        chk(c, 64'd0);
        chk(ls, 64'h01);
        i_vs_ok = 1'b0;
        wait_n(4);
        chk({hs, ls}, 64'h0);
        i_vs_ok = 1'b1;
        wait_n(4);
        chk(ls, 64'h01);
        $display("stop test done");
    endtask
    task automatic t_sleep();
        host_model_inst.put(5, 24'h0);
        chk(flag, 64'h1);
        host_model_inst.put(0, 24'h03);
        chk(fq, 64'(FREQ_200));
        i_en = 1'b0;
        wait_n(4);
        chk({hs, ls, cp, nm}, 64'h0);
        chk({fq, dc, asg, up, lo, fw}, 64'h0);
        host_model_inst.put(1, 24'hFFFFFF);
        i_en = 1'b1;
        wait_n(5);
        chk({dc, nm, flag}, 64'h2);
        $display("sleep test done");
    endtask
    task automatic t_vdd();
        host_model_inst.put(1, 24'h0000AA);
        host_model_inst.put(5, 24'h0);
        i_vdd_ok = 1'b0;
        wait_n(4);
        chk({hs, ls, nm, flag, dc}, 64'h0);
        i_vdd_ok = 1'b1;
        wait_n(5);
        chk({dc, nm, flag}, 64'h2);
        $display("supply test done");
    endtask
    // ****************************************************************
    // Sequence and watchdog
    // ****************************************************************
    initial begin
        wait_n(10);
        i_srst = 1'b0;
        wait_n(6);
        t_reset();
        t_static();
        t_pwm();
        t_stop();
        t_sleep();
        t_vdd();
        end_of_test();
    end
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end
endmodule
